// ===== shared/tsc_pkg.sv
// Shared constants and types for the scan timing controller ends
package tsc_pkg;
    // Port state machine, Gray steps from reset along the DR path to Exit1-DR
    typedef enum logic [3:0] {
        TSC_RESET   = 4'h0,
        TSC_IDLE    = 4'h1,
        TSC_SEL_DR  = 4'h3,
        TSC_CAP_DR  = 4'h2,
        TSC_SH_DR   = 4'h6,
        TSC_EX1_DR  = 4'h7,
        TSC_PAU_DR  = 4'h5,
        TSC_EX2_DR  = 4'h4,
        TSC_UPD_DR  = 4'hc,
        TSC_SEL_IR  = 4'hd,
        TSC_CAP_IR  = 4'hf,
        TSC_SH_IR   = 4'he,
        TSC_EX1_IR  = 4'ha,
        TSC_PAU_IR  = 4'hb,
        TSC_EX2_IR  = 4'h9,
        TSC_UPD_IR  = 4'h8
    } tsc_state_t;

    localparam int         TSC_IR_W      = 8;
    localparam logic [7:0] TSC_IR_CAPTURE = 8'h81;  // Captured pattern
    localparam logic [7:0] TSC_IR_BYPASS  = 8'hff;  // Bypass opcode
    localparam logic [7:0] TSC_IR_RESET   = 8'hff;  // Active after reset
    localparam logic       TSC_BYP_CAPTURE = 1'h0;
    localparam int         TSC_DR_W      = 32;      // Plain data register
    localparam logic [7:0] TSC_LEN_W     = 8'h20;   // Max scan length
    localparam int         TSC_CLK_DIV   = 10;      // Half period, clocks
    localparam logic [3:0] TSC_DIV_LAST  = 4'(TSC_CLK_DIV - 1);

    // Next state from current state and sampled mode select
    function automatic tsc_state_t tsc_next(input tsc_state_t s,
                                            input logic       m);
        case (s)
            TSC_RESET:  tsc_next = m ? TSC_RESET  : TSC_IDLE;
            TSC_IDLE:   tsc_next = m ? TSC_SEL_DR : TSC_IDLE;
            TSC_SEL_DR: tsc_next = m ? TSC_SEL_IR : TSC_CAP_DR;
            TSC_CAP_DR: tsc_next = m ? TSC_EX1_DR : TSC_SH_DR;
            TSC_SH_DR:  tsc_next = m ? TSC_EX1_DR : TSC_SH_DR;
            TSC_EX1_DR: tsc_next = m ? TSC_UPD_DR : TSC_PAU_DR;
            TSC_PAU_DR: tsc_next = m ? TSC_EX2_DR : TSC_PAU_DR;
            TSC_EX2_DR: tsc_next = m ? TSC_UPD_DR : TSC_SH_DR;
            TSC_UPD_DR: tsc_next = m ? TSC_SEL_DR : TSC_IDLE;
            TSC_SEL_IR: tsc_next = m ? TSC_RESET  : TSC_CAP_IR;
            TSC_CAP_IR: tsc_next = m ? TSC_EX1_IR : TSC_SH_IR;
            TSC_SH_IR:  tsc_next = m ? TSC_EX1_IR : TSC_SH_IR;
            TSC_EX1_IR: tsc_next = m ? TSC_UPD_IR : TSC_PAU_IR;
            TSC_PAU_IR: tsc_next = m ? TSC_EX2_IR : TSC_PAU_IR;
            TSC_EX2_IR: tsc_next = m ? TSC_UPD_IR : TSC_SH_IR;
            TSC_UPD_IR: tsc_next = m ? TSC_SEL_DR : TSC_IDLE;
            default:    tsc_next = TSC_RESET;
        endcase
    endfunction
endpackage

// ===== shared/tsc_if.sv
// Four-wire scan link between controller and device
`timescale 1ns/1ps
interface tsc_if;
    logic tck;       // Test clock, made by controller
    logic tms;       // Mode select
    logic tdi;       // Serial data into device
    logic tdo;       // Serial data out of device
    logic tdo_oe;    // Device drives serial output
    modport device (input tck, input tms, input tdi,
                    output tdo, output tdo_oe);
    modport ctrl   (output tck, output tms, output tdi,
                    input tdo, input tdo_oe);
endinterface

// ===== hdl/tsc_device.sv
// Device end: port state machine, instruction and bypass registers
//
// Summary of operation
// - All test state changes on test clock edges
// - Sample serial input, mode select on rise
// - Drive serial output only on fall
// - Controller changes mode select on fall
// - Low mode select leaves reset for idle
// - Capture-IR loads 10000001 into instruction shifter
// - Output enables on fall entering shift
// - Shift-IR shifts one bit per rise
// - Last bit shifts leaving shift state
// - Controller raises mode select on last shift
// - Exit1 state floats serial output on fall
// - Update-IR latches instruction on fall
// - All-ones instruction selects bypass register
// - Bypass captures zero leaving Capture-DR
// - Bypass delays serial stream one clock
// - Update-DR updates selected register on fall
// - Serial data moves only in shift states
`timescale 1ns/1ps
module tsc_device (
    // System
    input  wire logic     clock,
    input  wire logic     rst,
    // Scan link
    tsc_if.device         link,
    // User side
    output logic [7:0]    active_ir,
    output logic [31:0]   dr_update,
    output logic          bypass_sel,
    output logic [3:0]    tap_state
);
    import tsc_pkg::*;

    // Whole state of this end
    typedef struct packed {
        logic [1:0]  tck_s;      // Test clock synchroniser
        logic [1:0]  tms_s;      // Mode select synchroniser
        logic [1:0]  tdi_s;      // Serial in synchroniser
        logic        tck_d;      // Last synced clock, edge finder
        tsc_state_t  st;         // Port state
        logic [7:0]  ir_sh;      // Instruction shifter
        logic [7:0]  ir;         // Active instruction
        logic        byp;        // Bypass register
        logic [31:0] dr_sh;      // Plain data shifter
        logic [31:0] dr;         // Plain data latch
        logic        tdo;        // Serial out pin
        logic        tdo_oe;     // Serial out enable
        logic        byp_sel;    // Registered bypass decode
    } tsc_dev_t;

    tsc_dev_t r;        // Registered state
    tsc_dev_t next_r;   // Next state

    logic rise;         // Synced test clock rose
    logic fall;         // Synced test clock fell
    logic is_byp;       // Decoded bypass
    logic shifting;     // In either shift state

    // Decode of the bypass opcode
    function automatic logic dec_byp(input logic [7:0] op);
        dec_byp = (op == TSC_IR_BYPASS);
    endfunction

    // Next state of everything
    always_comb begin
        next_r       = r;
        next_r.tck_s = {r.tck_s[0], link.tck};
        next_r.tms_s = {r.tms_s[0], link.tms};
        next_r.tdi_s = {r.tdi_s[0], link.tdi};
        next_r.tck_d = r.tck_s[1];
        rise         = r.tck_s[1] & ~r.tck_d;
        fall         = ~r.tck_s[1] & r.tck_d;
        is_byp       = dec_byp(r.ir);
        shifting     = (r.st == TSC_SH_IR) || (r.st == TSC_SH_DR);
        // Rising test clock edge: sample and step
        if (rise) begin
            next_r.st = tsc_next(r.st, r.tms_s[1]);
            case (r.st)
                TSC_CAP_IR: begin
                    next_r.ir_sh = TSC_IR_CAPTURE;
                end
                TSC_SH_IR: begin
                    // Also on the exit step
                    next_r.ir_sh = {r.tdi_s[1], r.ir_sh[7:1]};
                end
                TSC_CAP_DR: begin
                    if (is_byp) begin
                        next_r.byp = TSC_BYP_CAPTURE;
                    end else begin
                        next_r.dr_sh = r.dr;
                    end
                end
                TSC_SH_DR: begin
                    // One-stage delay in bypass
                    if (is_byp) begin
                        next_r.byp = r.tdi_s[1];
                    end else begin
                        next_r.dr_sh = {r.tdi_s[1], r.dr_sh[31:1]};
                    end
                end
                default: begin
                    // Registers hold elsewhere
                end
            endcase
        end
        // Falling test clock edge: drive and update
        if (fall) begin
            next_r.tdo_oe = shifting;
            if (r.st == TSC_SH_IR) begin
                next_r.tdo = r.ir_sh[0];
            end else if (r.st == TSC_SH_DR) begin
                next_r.tdo = is_byp ? r.byp : r.dr_sh[0];
            end
            if (r.st == TSC_UPD_IR) begin
                next_r.ir = r.ir_sh;
            end
            if ((r.st == TSC_UPD_DR) && !is_byp) begin
                next_r.dr = r.dr_sh;
            end
            if (r.st == TSC_RESET) begin
                next_r.ir = TSC_IR_RESET;
            end
        end
        // Decode ahead so the output comes from a flip-flop
        next_r.byp_sel = dec_byp(next_r.ir);
    end

    // Register the whole state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r        <= '0;
            r.st     <= TSC_RESET;
            r.ir     <= TSC_IR_RESET;
            r.byp_sel <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops
    assign link.tdo    = r.tdo;
    assign link.tdo_oe = r.tdo_oe;
    assign active_ir   = r.ir;
    assign dr_update   = r.dr;
    assign bypass_sel  = r.byp_sel;
    assign tap_state   = r.st;
endmodule

// ===== hdl/tsc_ctrl.sv
// Controller end: makes the test clock and runs IR or DR scans
`timescale 1ns/1ps
module tsc_ctrl (
    // System
    input  wire logic        clock,
    input  wire logic        rst,
    // Scan link
    tsc_if.ctrl              link,
    // Request side, two-entry buffered
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_ir,      // 1: IR scan, 0: DR scan
    input  wire logic [7:0]  req_len,     // Bits, 1 to 32
    input  wire logic [31:0] req_data,    // LSB first
    // Answer side
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic [31:0]      rsp_data
);
    import tsc_pkg::*;

    typedef struct packed {
        logic        v;
        logic        ir;
        logic [7:0]  len;
        logic [31:0] d;
    } tsc_req_t;

    typedef struct packed {
        tsc_req_t [1:0] q;       // Request buffer
        logic        wp;         // Write slot
        logic        rp;         // Read slot
        logic [3:0]  div;        // Clock divider
        logic        tck;
        logic        tms;
        logic        tdi;
        logic [1:0]  tdo_s;      // Serial out synchroniser
        logic [5:0]  step;       // Position in scan walk
        logic        busy;
        tsc_req_t    cur;        // Scan in progress
        logic [7:0]  cnt;        // Bits left
        logic [31:0] cap;        // Collected bits
        logic        rv;         // Answer valid
        logic [31:0] rd;         // Answer word
        logic        rdy;        // Ready toward source
    } tsc_ctl_t;

    tsc_ctl_t r;
    tsc_ctl_t next_r;
    logic     tick_fall;   // Clock is about to fall

    // Walk: idle, select-DR, [select-IR], capture, shift..., exit1,
    // update, idle. Mode select changes only while the clock falls.
    always_comb begin
        next_r       = r;
        tick_fall    = 1'b0;
        next_r.tdo_s = {r.tdo_s[0], link.tdo};
        // Push a request when a slot is free
        if (req_valid && r.rdy) begin
            next_r.q[r.wp] = '{v: 1'b1, ir: req_ir, len: req_len,
                               d: req_data};
            next_r.wp      = ~r.wp;
        end
        // Answer drained
        if (r.rv && rsp_ready) begin
            next_r.rv = 1'b0;
        end
        // Divider and clock
        if (r.div == TSC_DIV_LAST) begin
            next_r.div = 4'h0;
            next_r.tck = ~r.tck;
            tick_fall  = r.tck;
        end else begin
            next_r.div = r.div + 4'h1;
        end
        // Rising edge: capture the serial output of the device
        // Only rises that leave a shift state; the one leaving capture
        // still sees stale serial out, the last one already sits in step 6
        if ((r.div == TSC_DIV_LAST) && !r.tck && r.busy &&
            (((r.step == 6'h4 + 6'(r.cur.ir)) && (r.cnt != r.cur.len)) ||
             (r.step == 6'h6))) begin
            next_r.cap = {r.tdo_s[1], r.cap[31:1]};
        end
        // Falling edge: step the walk
        if (tick_fall) begin
            if (!r.busy) begin
                next_r.tms = 1'b0;
                // Start only once a low mode select has been clocked in,
                // so the device has left reset for idle
                if (r.q[r.rp].v && !r.rv && !r.tms) begin
                    next_r.cur         = r.q[r.rp];
                    next_r.q[r.rp].v   = 1'b0;
                    next_r.rp          = ~r.rp;
                    next_r.busy        = 1'b1;
                    next_r.step        = 6'h1;
                    next_r.cnt         = r.q[r.rp].len;
                    next_r.cap         = '0;
                    next_r.tms         = 1'b1;
                end
            end else begin
                case (r.step)
                    6'h1: begin
                        next_r.tms  = r.cur.ir;
                        next_r.step = r.cur.ir ? 6'h2 : 6'h3;
                    end
                    6'h2: begin
                        next_r.tms  = 1'b0;
                        next_r.step = 6'h3;
                    end
                    6'h3: begin
                        // In capture: always go on into shift
                        next_r.tms  = 1'b0;
                        next_r.step = 6'h4 + 6'(r.cur.ir);
                    end
                    6'h4, 6'h5: begin
                        // In shift: present bit on fall
                        next_r.tdi   = r.cur.d[0];
                        next_r.cur.d = {1'b0, r.cur.d[31:1]};
                        next_r.cnt   = r.cnt - 8'h1;
                        // Raise mode select on the last bit
                        next_r.tms   = (r.cnt <= 8'h1);
                        if (r.cnt <= 8'h1) begin
                            next_r.step = 6'h6;
                        end
                    end
                    6'h6: begin
                        // In exit1: on to update
                        next_r.tms  = 1'b1;
                        next_r.step = 6'h7;
                    end
                    6'h7: begin
                        // In update: back to idle
                        next_r.tms  = 1'b0;
                        next_r.step = 6'h8;
                    end
                    default: begin
                        // Back in idle: hand over the answer
                        next_r.busy = 1'b0;
                        next_r.tms  = 1'b0;
                        next_r.rv   = 1'b1;
                        next_r.rd   = r.cap >> 6'(TSC_LEN_W - r.cur.len);
                    end
                endcase
            end
        end
        next_r.rdy = !(next_r.q[0].v && next_r.q[1].v);
    end

    // Register the whole state; reset walks into Test-Logic-Reset first
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r     <= '0;
            r.tms <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.tck  = r.tck;
    assign link.tms  = r.tms;
    assign link.tdi  = r.tdi;
    assign req_ready = r.rdy;
    assign rsp_valid = r.rv;
    assign rsp_data  = r.rd;
endmodule

// ===== tb/tsc_props.sv
// Concurrent checks on the scan link between the two ends
`timescale 1ns/1ps
module tsc_props
    import tsc_pkg::*;
(
    // System
    input wire logic clock,
    input wire logic rst,
    // Scan link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    import tsc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic       tck_q;   // Test clock one cycle ago
    logic       rise;    // Test clock rose this cycle
    tsc_state_t st;      // Link state as the wires tell it

    assign rise = tck & ~tck_q;

    // Track the link state from the wires alone
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tck_q <= 1'b0;
            st    <= TSC_RESET;
        end else begin
            tck_q <= tck;
            if (rise) begin
                st <= tsc_next(st, tms);
            end
        end
    end

    a_tdo_on_fall: assert property ($changed(tdo) |-> !tck)
        else $error("serial out moved while test clock high");
    a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck)
        else $error("output enable moved while test clock high");
    a_tms_on_fall: assert property ($changed(tms) |-> !tck)
        else $error("mode select moved while test clock high");
    a_tdi_on_fall: assert property ($changed(tdi) |-> !tck)
        else $error("serial in moved while test clock high");
    a_tck_high_half: assert property ($rose(tck) |-> ##9 tck ##1 !tck)
        else $error("test clock high phase not ten cycles");
    a_oe_rise_shift: assert property ($rose(tdo_oe) |->
        (st == TSC_SH_IR || st == TSC_SH_DR))
        else $error("output enabled outside a shift state");
    a_oe_fell_exit: assert property ($fell(tdo_oe) |->
        (st == TSC_EX1_IR || st == TSC_EX1_DR))
        else $error("output floated outside first exit state");
    a_oe_on_time: assert property (rise && !tms &&
        (st == TSC_CAP_IR || st == TSC_CAP_DR) |-> ##[11:16] tdo_oe)
        else $error("output not enabled on fall entering shift");
    a_ir_capture: assert property ($rose(tdo_oe) && st == TSC_SH_IR
        |-> tdo ##20 !tdo)
        else $error("captured instruction not shifted out first");
endmodule

// ===== tb/tap_scan_timing_controller_test.sv
// Bench joining controller and device ends across the scan link
`timescale 1ns/1ps
module tap_scan_timing_controller_test;
    import tsc_pkg::*;
    logic        clock;            // System clock, 4 ns
    logic        rst;              // Reset, high active
    logic        req_valid;        // Request side
    logic        req_ready;
    logic        req_ir;
    logic [7:0]  req_len;
    logic [31:0] req_data;
    logic        rsp_valid;        // Answer side
    logic        rsp_ready;
    logic [31:0] rsp_data;
    logic [7:0]  active_ir;        // Device user side
    logic [31:0] dr_update;
    logic        bypass_sel;
    logic [3:0]  tap_state;
    logic [31:0] r;                // Last answer
    int          num_errors;
    int          samples_checked;

    tsc_if lnk ();
    tsc_ctrl u_tsc_ctrl (.clock(clock), .rst(rst), .link(lnk),
        .req_valid(req_valid), .req_ready(req_ready), .req_ir(req_ir),
        .req_len(req_len), .req_data(req_data), .rsp_valid(rsp_valid),
        .rsp_ready(rsp_ready), .rsp_data(rsp_data));
    tsc_device u_tsc_device (.clock(clock), .rst(rst), .link(lnk),
        .active_ir(active_ir), .dr_update(dr_update),
        .bypass_sel(bypass_sel), .tap_state(tap_state));
    tsc_props u_tsc_props (.clock(clock), .rst(rst), .tck(lnk.tck),
        .tms(lnk.tms), .tdi(lnk.tdi), .tdo(lnk.tdo), .tdo_oe(lnk.tdo_oe));

    // Clock, toggled each half period
    always #2 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Offer one request, held until the edge that takes it
    task automatic push(input logic ir, input logic [7:0] len,
                        input logic [31:0] data);
        int n;
        @(negedge clock);
        req_valid = 1'b1;
        req_ir    = ir;
        req_len   = len;
        req_data  = data;
        for (n = 0; n < 8000; n++) begin
            @(posedge clock);
            if (req_ready === 1'b1) break;
        end
        if (n == 8000) check(32'h0, 32'h1);
        @(negedge clock);
        req_valid = 1'b0;
    endtask

    // Take one answer at the edge where it is valid
    task automatic pop(output logic [31:0] d);
        int n;
        @(negedge clock);
        rsp_ready = 1'b1;
        for (n = 0; n < 8000; n++) begin
            @(posedge clock);
            if (rsp_valid === 1'b1) break;
        end
        if (n == 8000) check(32'h0, 32'h1);
        d = rsp_data;
        @(negedge clock);
        rsp_ready = 1'b0;
    endtask

    // Whole scan, then wait for the walk back to idle
    task automatic scan(input logic ir, input logic [7:0] len,
                        input logic [31:0] data);
        int n;
        push(ir, len, data);
        pop(r);
        for (n = 0; n < 2000 && tap_state !== TSC_IDLE; n++)
            @(negedge clock);
    endtask

    // Capture pattern out, all-ones becomes bypass
    task automatic t_ir_capture();
        scan(1'b1, 8'h08, 32'hff);
        check(r & 32'hff, 32'h81);
        check({24'h0, active_ir}, 32'hff);
        check({31'h0, bypass_sel}, 32'h1);
    endtask

    // Bypass delays by one, zero first
    task automatic t_bypass();
        scan(1'b0, 8'h03, 32'h5);
        check(r & 32'h7, 32'h2);
        scan(1'b0, 8'h20, 32'ha5c3_0f96);
        check(r, 32'h4b86_1f2c);
    endtask

    // Plain register: update on exit, capture on next scan
    task automatic t_plain_dr();
        scan(1'b1, 8'h08, 32'h01);
        check(r & 32'hff, 32'h81);
        check({24'h0, active_ir}, 32'h01);
        check({31'h0, bypass_sel}, 32'h0);
        scan(1'b0, 8'h20, 32'h1234_5678);
        check(dr_update, 32'h1234_5678);
        scan(1'b0, 8'h20, 32'h0f0f_00ff);
        check(r, 32'h1234_5678);
        check(dr_update, 32'h0f0f_00ff);
    endtask

    // Fill both slots with answers stalled, then drain in order
    task automatic t_fill();
        int k;
        int i;
        scan(1'b1, 8'h08, 32'hff);
        for (k = 0; k < 8; k++) begin
            repeat (30) @(negedge clock);
            if (req_ready !== 1'b1) break;
            push(1'b0, 8'h08, 32'(8'h35 ^ (k * 8'h1d)));
        end
        check({31'h0, req_ready}, 32'h0);
        for (i = 0; i < k; i++) begin
            pop(r);
            check(r & 32'hff, 32'((8'h35 ^ (i * 8'h1d)) << 1) & 32'hff);
        end
    endtask

    // Reset in mid-scan, then a fresh scan from reset
    task automatic t_reset();
        push(1'b0, 8'h20, 32'hdead_0001);
        repeat (200) @(negedge clock);
        rst = 1'b1;
        repeat (3) @(negedge clock);
        check({28'h0, tap_state}, {28'h0, TSC_RESET});
        check({24'h0, active_ir}, 32'hff);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        scan(1'b1, 8'h08, 32'h01);
        check(r & 32'hff, 32'h81);
        check({24'h0, active_ir}, 32'h01);
    endtask

    // Main sequence
    initial begin
        clock           = 1'b0;
        rst             = 1'b1;
        req_valid       = 1'b0;
        req_ir          = 1'b0;
        req_len         = 8'h0;
        req_data        = 32'h0;
        rsp_ready       = 1'b0;
        num_errors      = 0;
        samples_checked = 0;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        t_ir_capture();
        t_bypass();
        t_plain_dr();
        t_fill();
        t_reset();
        results();
    end

    // Watchdog, well past the expected run
    initial begin
        #400000;
        num_errors++;
        results();
    end
endmodule
